// ### logic/bist_consts.vh
// Purpose: constants shared by the datapath self-test block
// Assumes: register indexes are word indexes on the bus, byte address = 4 * index
// Notes:   values are 16-bit register contents unless marked otherwise
`ifndef BIST_CONSTS_VH
`define BIST_CONSTS_VH
// register indexes
`define IDX_BASIC_CTRL     12'h000
`define IDX_LOOPBACK_CTRL  12'h016
`define IDX_CABLE_TX_CTRL  12'h41f
`define IDX_SERIAL_CTRL    12'h42c
`define IDX_GEN_CTRL       12'h619
`define IDX_PRBS_STATUS    12'h620
`define IDX_PKT_CONFIG     12'h624
`define IDX_RX_CNT_LOW     12'h63c
`define IDX_RX_CNT_HIGH    12'h63d
`define IDX_CRC_ERR_CNT    12'h63e
`define IDX_IRQ_STATUS     12'h700
`define IDX_IRQ_MASK       12'h701
// field positions
`define BIT_MAC_LOOP       14
`define BIT_REV_LOOP       4
`define BIT_CABLE_SUPPRESS 12
`define BIT_GEN_ENABLE     0
`define BIT_GEN_PRBS       1
`define BIT_CHK_ENABLE     2
`define BIT_PRBS_RESTART   1
`define BIT_PRBS_LOCK      8
// interrupt status bits
`define IRQ_RX_PKT         0
`define IRQ_CRC_ERR        1
`define IRQ_PRBS_LOCK      2
`define IRQ_PRBS_ERR       3
// reset and check values
`define RST_REG16          16'h0000
`define RST_CRC            32'hffffffff
`define CRC_RESIDUE        32'hdebb20e3
`define PRBS_SEED          7'h7f
// timing counts, in link byte slots
`define GAP_BYTES          8'd12
`define LOCK_BYTES         4'd8
`endif

// ### logic/datapath_loopback_bist.v
// Purpose: datapath self-test: MAC loopback, reverse loopback, packet and PRBS generator, checker, counters
// Assumes: byte-wide link lanes change on the falling link clock edge and are taken on its rising edge
// Notes:   link clock and lanes are sampled by clk_i through two flip-flops; clk_i must exceed 4x link clock
// How it works
// - basic control bit 14 (value 0x4140) loops MAC transmit bytes onto MAC receive lanes.
// - RGMII loopback echoes MAC transmit data; generator control 0x1004 enables checker only.
// - SGMII loopback echoes the same way; generator control 0x1114 enables checker only.
// - loopback control 0x0010 turns line receive traffic back to the cable; checker still runs.
// - serial MAC control 0x0010 does the same reverse loopback; packet and PRBS checkers run.
// - packet config 0x55BF with generator control 0x1555 sends packets and enables checker.
// - packet config 0x55BF with generator control 0x0557 sends PRBS and enables PRBS checker.
// - a 32-bit received packet count, low half at 0x063C, high at 0x063D.
// - packets with bad frame check sequence are counted, readable at 0x063E.
// - writing bit 1 at 0x0620 restarts PRBS error byte count, read in bits 7:0.
// - bit 8 at 0x0620 reads one while PRBS arrives and checker is locked.
// - PRBS checking only applies to internal generator data, never in MAC loopback.
// - the cable gets reverse-looped, else generator, else MAC transmit traffic, unless cable transmit control bit 12 is set.
// - in MAC loopback the packet and CRC error counters tally the looped packets.
//
// Register access over Wishbone was left to the implementer.
`include "bist_consts.vh"
module datapath_loopback_bist #(
  parameter PKT_LEN_W = 8
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [13:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // link clock and MAC side lanes
  input  wire        link_clk_i,
  input  wire [7:0]  mac_txd_i,
  input  wire        mac_tx_en_i,
  output reg  [7:0]  mac_rxd_o,
  output reg         mac_rx_dv_o,
  // cable side lanes
  input  wire [7:0]  line_rxd_i,
  input  wire        line_rx_dv_i,
  output reg  [7:0]  line_txd_o,
  output reg         line_tx_en_o,
  // interrupt
  output reg         irq_o
);

  // reflected crc-32, one byte
  function [31:0] crc_byte;
    input [31:0] c;
    input [7:0]  d;
    integer      i;
    reg   [31:0] r;
    begin
      r = c;
      for (i = 0; i < 8; i = i + 1) begin
        if (r[0] ^ d[i])
          r = (r >> 1) ^ 32'hedb88320;
        else
          r = r >> 1;
      end
      crc_byte = r;
    end
  endfunction

  // prbs7 (x^7 + x^6 + 1), eight bits per call; low 7 bits of result = new state
  function [14:0] prbs_byte;
    input [6:0] s;
    integer     i;
    reg   [6:0] r;
    reg   [7:0] o;
    begin
      r = s;
      o = 8'h00;
      for (i = 0; i < 8; i = i + 1) begin
        o[i] = r[6] ^ r[5];
        r    = {r[5:0], r[6] ^ r[5]};
      end
      prbs_byte = {o, r};
    end
  endfunction

  // two-flop synchronisers for the link clock and lane inputs; stage one feeds only stage two
  reg  [18:0] sync1_q;
  reg  [18:0] sync2_q;
  reg         link_clk_d1_q;
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q       <= 19'h00000;
      sync2_q       <= 19'h00000;
      link_clk_d1_q <= 1'b0;
    end else begin
      sync1_q       <= {link_clk_i, mac_tx_en_i, mac_txd_i, line_rx_dv_i, line_rxd_i};
      sync2_q       <= sync1_q;
      link_clk_d1_q <= sync2_q[18];
    end
  end
  wire       link_rise = sync2_q[18] & ~link_clk_d1_q;
  wire       mtx_en    = sync2_q[17];
  wire [7:0] mtxd      = sync2_q[16:9];
  wire       lrx_dv    = sync2_q[8];
  wire [7:0] lrxd_in   = sync2_q[7:0];

  // software registers
  reg  [15:0] basic_control_q;
  reg  [15:0] loopback_control_q;
  reg  [15:0] cable_tx_control_q;
  reg  [15:0] serial_mac_control_q;
  reg  [15:0] generator_control_q;
  reg  [15:0] packet_config_q;
  reg  [3:0]  irq_status_q;
  reg  [3:0]  irq_mask_q;
  reg  [31:0] rx_pkt_cnt_q;
  reg  [15:0] rx_cnt_high_hold_q;
  reg  [15:0] crc_err_cnt_q;
  reg  [7:0]  prbs_err_cnt_q;
  reg         prbs_lock_q;

  // mode decode
  wire mac_loop   = basic_control_q[`BIT_MAC_LOOP];
  wire rev_loop   = loopback_control_q[`BIT_REV_LOOP] | serial_mac_control_q[`BIT_REV_LOOP];
  wire suppress   = cable_tx_control_q[`BIT_CABLE_SUPPRESS];
  wire gen_on     = generator_control_q[`BIT_GEN_ENABLE] & ~mac_loop;
  wire gen_prbs   = generator_control_q[`BIT_GEN_PRBS];
  wire chk_on     = generator_control_q[`BIT_CHK_ENABLE];
  wire prbs_chk   = chk_on & gen_prbs & generator_control_q[`BIT_GEN_ENABLE] & ~mac_loop;

  // bus decode; writes and reads happen on the edge that raises ack
  wire        wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wb_wr   = wb_req & wb_we_i;
  wire [11:0] idx     = wb_adr_i[13:2];
  wire [15:0] wmask   = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire        prbs_restart = wb_wr & (idx == `IDX_PRBS_STATUS) & wb_sel_i[0] & wb_dat_i[`BIT_PRBS_RESTART];

  // generator: packets of incrementing bytes plus fcs, or continuous prbs
  localparam G_IDLE = 2'd0;
  localparam G_DATA = 2'd1;
  localparam G_FCS  = 2'd2;
  localparam G_GAP  = 2'd3;
  reg  [1:0]           gen_state_q;
  reg  [PKT_LEN_W-1:0] gen_cnt_q;
  reg  [31:0]          gen_crc_q;
  reg  [6:0]           gen_prbs_q;
  reg  [7:0]           gen_byte;
  reg                  gen_valid;
  wire [14:0]          gen_prbs_nx = prbs_byte(gen_prbs_q);
  wire [31:0]          gen_fcs     = ~gen_crc_q;
  wire [PKT_LEN_W-1:0] pkt_len     = packet_config_q[PKT_LEN_W-1:0];

  // generator output byte for this slot
  always @* begin
    gen_byte  = 8'h00;
    gen_valid = 1'b0;
    if (gen_on && gen_prbs) begin
      gen_byte  = gen_prbs_nx[14:7];
      gen_valid = 1'b1;
    end else if (gen_on && gen_state_q == G_DATA) begin
      gen_byte  = gen_cnt_q[7:0];
      gen_valid = 1'b1;
    end else if (gen_state_q == G_FCS) begin
      gen_byte  = gen_fcs[8*gen_cnt_q[1:0] +: 8];
      gen_valid = 1'b1;
    end
  end

  // generator sequencing, one step per link byte slot
  always @(posedge clk_i) begin
    if (rst_i) begin
      gen_state_q <= G_IDLE;
      gen_cnt_q   <= {PKT_LEN_W{1'b0}};
      gen_crc_q   <= `RST_CRC;
      gen_prbs_q  <= `PRBS_SEED;
    end else if (link_rise) begin
      gen_prbs_q <= gen_prbs_nx[6:0];
      case (gen_state_q)
        G_IDLE: begin
          gen_cnt_q <= {PKT_LEN_W{1'b0}};
          gen_crc_q <= `RST_CRC;
          if (gen_on && !gen_prbs)
            gen_state_q <= G_DATA;
        end
        G_DATA: begin
          gen_crc_q <= crc_byte(gen_crc_q, gen_byte);
          if (!gen_on || gen_prbs) begin
            gen_state_q <= G_IDLE;
          end else if (gen_cnt_q == pkt_len) begin
            gen_cnt_q   <= {PKT_LEN_W{1'b0}};
            gen_state_q <= G_FCS;
          end else begin
            gen_cnt_q <= gen_cnt_q + 1'b1;
          end
        end
        G_FCS: begin
          if (gen_cnt_q[1:0] == 2'd3) begin
            gen_cnt_q   <= {PKT_LEN_W{1'b0}};
            gen_state_q <= G_GAP;
          end else begin
            gen_cnt_q <= gen_cnt_q + 1'b1;
          end
        end
        G_GAP: begin
          gen_cnt_q <= gen_cnt_q + 1'b1;
          if (gen_cnt_q[7:0] == `GAP_BYTES - 8'd1) begin
            gen_cnt_q   <= {PKT_LEN_W{1'b0}};
            gen_crc_q   <= `RST_CRC;
            gen_state_q <= G_IDLE;
          end
        end
        default: gen_state_q <= G_IDLE;
      endcase
    end
  end

  // checker input: looped MAC traffic in MAC loopback, otherwise cable receive
  wire       chk_dv   = mac_loop ? mtx_en : lrx_dv;
  wire [7:0] chk_byte = mac_loop ? mtxd : lrxd_in;

  // packet checker: crc over each frame, judged when valid drops
  reg         chk_dv_q;
  reg  [31:0] chk_crc_q;
  reg  [6:0]  chk_prbs_q;
  reg  [3:0]  lock_run_q;
  wire        pkt_end  = link_rise & chk_dv_q & ~chk_dv & chk_on;
  wire        crc_bad  = pkt_end & (chk_crc_q != `CRC_RESIDUE);
  wire [14:0] chk_pred = prbs_byte(chk_prbs_q);
  wire        prbs_mis = link_rise & chk_dv & prbs_chk & (chk_pred[14:7] != chk_byte);
  wire        prbs_hit = link_rise & chk_dv & prbs_chk & (chk_pred[14:7] == chk_byte);
  wire        lock_gain = prbs_hit & ~prbs_lock_q & (lock_run_q == `LOCK_BYTES - 4'd1);

  // checker state; prbs checker re-seeds itself from the received bits
  always @(posedge clk_i) begin
    if (rst_i) begin
      chk_dv_q    <= 1'b0;
      chk_crc_q   <= `RST_CRC;
      chk_prbs_q  <= `PRBS_SEED;
      lock_run_q  <= 4'h0;
      prbs_lock_q <= 1'b0;
    end else if (link_rise) begin
      chk_dv_q <= chk_dv;
      if (chk_dv)
        chk_crc_q <= crc_byte(chk_crc_q, chk_byte);
      else
        chk_crc_q <= `RST_CRC;
      if (chk_dv)
        chk_prbs_q <= {chk_byte[1], chk_byte[2], chk_byte[3], chk_byte[4],
                       chk_byte[5], chk_byte[6], chk_byte[7]};
      if (!prbs_chk || !chk_dv) begin
        lock_run_q  <= 4'h0;
        prbs_lock_q <= 1'b0;
      end else if (prbs_mis) begin
        lock_run_q  <= 4'h0;
        prbs_lock_q <= 1'b0;
      end else if (lock_run_q != `LOCK_BYTES - 4'd1) begin
        lock_run_q <= lock_run_q + 4'd1;
      end else begin
        prbs_lock_q <= 1'b1;
      end
    end
  end

  // counters; a restart write wins only over the count of its own cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_pkt_cnt_q   <= 32'h00000000;
      crc_err_cnt_q  <= 16'h0000;
      prbs_err_cnt_q <= 8'h00;
    end else begin
      if (pkt_end)
        rx_pkt_cnt_q <= rx_pkt_cnt_q + 32'h00000001;
      if (crc_bad)
        crc_err_cnt_q <= crc_err_cnt_q + 16'h0001;
      if (prbs_restart)
        prbs_err_cnt_q <= 8'h00;
      else if (prbs_mis && prbs_lock_q && prbs_err_cnt_q != 8'hff)
        prbs_err_cnt_q <= prbs_err_cnt_q + 8'h01;
    end
  end

  // datapath steering, registered outputs updated on each link slot
  always @(posedge clk_i) begin
    if (rst_i) begin
      mac_rxd_o    <= 8'h00;
      mac_rx_dv_o  <= 1'b0;
      line_txd_o   <= 8'h00;
      line_tx_en_o <= 1'b0;
    end else if (link_rise) begin
      mac_rxd_o   <= mac_loop ? mtxd : lrxd_in;
      mac_rx_dv_o <= mac_loop ? mtx_en : lrx_dv;
      if (suppress) begin
        line_txd_o   <= 8'h00;
        line_tx_en_o <= 1'b0;
      end else if (rev_loop) begin
        line_txd_o   <= lrxd_in;
        line_tx_en_o <= lrx_dv;
      end else if (gen_on) begin
        line_txd_o   <= gen_byte;
        line_tx_en_o <= gen_valid;
      end else begin
        line_txd_o   <= mtxd;
        line_tx_en_o <= mtx_en;
      end
    end
  end

  // interrupt events
  wire [3:0] irq_evt = {prbs_mis & prbs_lock_q, lock_gain, crc_bad, pkt_end};

  // register writes; hardware set wins over a write-one clear in the same cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      basic_control_q      <= `RST_REG16;
      loopback_control_q   <= `RST_REG16;
      cable_tx_control_q   <= `RST_REG16;
      serial_mac_control_q <= `RST_REG16;
      generator_control_q  <= `RST_REG16;
      packet_config_q      <= `RST_REG16;
      irq_mask_q           <= 4'h0;
      irq_status_q         <= 4'h0;
    end else begin
      irq_status_q <= irq_status_q | irq_evt;
      if (wb_wr) begin
        case (idx)
          `IDX_BASIC_CTRL:    basic_control_q      <= (basic_control_q & ~wmask) | (wb_dat_i[15:0] & wmask);
          `IDX_LOOPBACK_CTRL: loopback_control_q   <= (loopback_control_q & ~wmask) | (wb_dat_i[15:0] & wmask);
          `IDX_CABLE_TX_CTRL: cable_tx_control_q   <= (cable_tx_control_q & ~wmask) | (wb_dat_i[15:0] & wmask);
          `IDX_SERIAL_CTRL:   serial_mac_control_q <= (serial_mac_control_q & ~wmask) | (wb_dat_i[15:0] & wmask);
          `IDX_GEN_CTRL:      generator_control_q  <= (generator_control_q & ~wmask) | (wb_dat_i[15:0] & wmask);
          `IDX_PKT_CONFIG:    packet_config_q      <= (packet_config_q & ~wmask) | (wb_dat_i[15:0] & wmask);
          `IDX_IRQ_MASK: begin
            if (wb_sel_i[0])
              irq_mask_q <= wb_dat_i[3:0];
          end
          `IDX_IRQ_STATUS: begin
            if (wb_sel_i[0])
              irq_status_q <= (irq_status_q & ~wb_dat_i[3:0]) | irq_evt;
          end
          default: ;
        endcase
      end
    end
  end

  // read mux
  reg [15:0] rd_val;
  always @* begin
    case (idx)
      `IDX_BASIC_CTRL:    rd_val = basic_control_q;
      `IDX_LOOPBACK_CTRL: rd_val = loopback_control_q;
      `IDX_CABLE_TX_CTRL: rd_val = cable_tx_control_q;
      `IDX_SERIAL_CTRL:   rd_val = serial_mac_control_q;
      `IDX_GEN_CTRL:      rd_val = generator_control_q;
      `IDX_PRBS_STATUS:   rd_val = {7'h00, prbs_lock_q, prbs_err_cnt_q};
      `IDX_PKT_CONFIG:    rd_val = packet_config_q;
      `IDX_RX_CNT_LOW:    rd_val = rx_pkt_cnt_q[15:0];
      `IDX_RX_CNT_HIGH:   rd_val = rx_cnt_high_hold_q;
      `IDX_CRC_ERR_CNT:   rd_val = crc_err_cnt_q;
      `IDX_IRQ_STATUS:    rd_val = {12'h000, irq_status_q};
      `IDX_IRQ_MASK:      rd_val = {12'h000, irq_mask_q};
      default:            rd_val = 16'h0000;
    endcase
  end

  // bus answer: one wait state, ack for one cycle, unmapped reads return zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o           <= 1'b0;
      wb_dat_o           <= 32'h00000000;
      rx_cnt_high_hold_q <= 16'h0000;
      irq_o              <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i)
        wb_dat_o <= {16'h0000, rd_val};
      if (wb_req && !wb_we_i && idx == `IDX_RX_CNT_LOW)
        rx_cnt_high_hold_q <= rx_pkt_cnt_q[31:16];
      irq_o <= |(irq_status_q & irq_mask_q);
    end
  end

endmodule // datapath_loopback_bist

// ### dv/datapath_loopback_bist_assertions.sv
// Purpose: port checks for the datapath self-test block
// Assumes: word index in adr[13:2]; mode bits shadowed from bus writes
// Notes:   a link slot is 8 clk, so 14 clk bounds any lane latency
`include "bist_consts.vh"
module bist_checker #(
  parameter PKT_LEN_W = 8
) (
  // clock and reset
  input wire        clk_i,
  input wire        rst_i,
  // bus
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [13:0] wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  // lanes and interrupt
  input wire        link_clk_i,
  input wire [7:0]  mac_txd_i,
  input wire        mac_tx_en_i,
  input wire [7:0]  mac_rxd_o,
  input wire        mac_rx_dv_o,
  input wire [7:0]  line_rxd_i,
  input wire        line_rx_dv_i,
  input wire [7:0]  line_txd_o,
  input wire        line_tx_en_o,
  input wire        irq_o
);
  logic        mac_q;
  logic        supp_q;
  logic [1:0]  rev_q;
  logic [15:0] mask_q;
  wire         wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  wire  [11:0] idx = wb_adr_i[13:2];
  // shadow the mode bits; a write lands on the edge that takes it, as in the block
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mac_q  <= 1'b0;
      supp_q <= 1'b0;
      rev_q  <= 2'b00;
      mask_q <= 16'h0000;
    end else if (wr) begin
      if (idx == `IDX_BASIC_CTRL) mac_q <= wb_dat_i[`BIT_MAC_LOOP];
      if (idx == `IDX_CABLE_TX_CTRL) supp_q <= wb_dat_i[`BIT_CABLE_SUPPRESS];
      if (idx == `IDX_LOOPBACK_CTRL) rev_q[0] <= wb_dat_i[`BIT_REV_LOOP];
      if (idx == `IDX_SERIAL_CTRL) rev_q[1] <= wb_dat_i[`BIT_REV_LOOP];
      if (idx == `IDX_IRQ_MASK) mask_q <= wb_dat_i[15:0];
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ack_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
  property p_ack_next; s_req |=> s_ack_pulse; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack not a one cycle answer");
  property p_ack_cause; wb_ack_o |-> $past(wb_stb_i) && !$past(wb_ack_o); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_hi; wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000; endproperty
  a_dat_hi: assert property (p_dat_hi) else $error("read data upper half not zero");
  property p_mac_echo; mac_q && $rose(mac_tx_en_i) |-> ##[1:14] mac_rx_dv_o; endproperty
  a_mac_echo: assert property (p_mac_echo) else $error("mac loop echo missing");
  property p_copy;
    mac_q && !supp_q && rev_q == 2'b00 && $rose(mac_rx_dv_o) |-> line_tx_en_o && line_txd_o == mac_rxd_o;
  endproperty
  a_copy: assert property (p_copy) else $error("looped byte not sent to cable");
  property p_supp; $rose(line_tx_en_o) |-> !supp_q; endproperty
  a_supp: assert property (p_supp) else $error("cable sent while suppressed");
  property p_rev; rev_q != 2'b00 && !supp_q && !mac_q && $rose(line_rx_dv_i) |-> ##[1:14] line_tx_en_o; endproperty
  a_rev: assert property (p_rev) else $error("reverse loop missing");
  property p_irq; $past(mask_q) == 16'h0000 |-> !irq_o; endproperty
  a_irq: assert property (p_irq) else $error("irq with all masked");
endmodule // bist_checker

// ### dv/mac_link_model.sv
// Purpose: MAC partner: link clock, frame sender, echo checker
// Assumes: lanes change on the falling link edge, taken on the rising one
// Notes:   link clock runs free, as a MAC interface clock does
module mac_link_model (
  // link clock and transmit lane
  output logic       link_clk_o,
  output logic [7:0] mac_txd_o,
  output logic       mac_tx_en_o,
  // receive lane
  input  wire  [7:0] mac_rxd_i,
  input  wire        mac_rx_dv_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] out_q[$];
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  logic       dv_q = 1'b0;
  int         echo_ok = 0;
  // 400 ns link clock and idle lane at time zero
  initial begin
    link_clk_o = 1'b0;
    mac_tx_en_o = 1'b0;
    mac_txd_o = 8'h00;
    forever #200 link_clk_o = ~link_clk_o;
  end
  // one byte per slot; an idle lane toggles so a stale byte never looks valid
  always @(negedge link_clk_o) begin
    mac_tx_en_o <= out_q.size() != 0;
    mac_txd_o   <= out_q.size() != 0 ? out_q.pop_front() : ~mac_txd_o;
  end
  // counting pattern plus reflected crc-32, lsb first; bad flips one fcs bit
  task automatic send_frame(input int len, input bit bad);
    logic [31:0] crc;
    crc = 32'hffffffff;
    tx_q.delete();
    for (int i = 0; i < len; i++) begin
      tx_q.push_back(i[7:0]);
      crc = crc ^ {24'h000000, i[7:0]};
      for (int k = 0; k < 8; k++) crc = crc[0] ? (crc >> 1) ^ 32'hedb88320 : crc >> 1;
    end
    crc = ~crc ^ {31'h00000000, bad};
    for (int i = 0; i < 4; i++) tx_q.push_back(crc[8*i +: 8]);
    foreach (tx_q[i]) out_q.push_back(tx_q[i]);
    wait (out_q.size() == 0);
    repeat (16) @(negedge link_clk_o);
  endtask
  // gather what comes back and compare it with the frame sent
  always @(posedge link_clk_o) begin
    dv_q <= mac_rx_dv_i;
    if (mac_rx_dv_i) rx_q.push_back(mac_rxd_i);
    else if (dv_q) begin
      if (rx_q == tx_q) echo_ok++;
      rx_q.delete();
    end
  end
endmodule // mac_link_model

// ### dv/datapath_loopback_bist_tb.sv
// Purpose: self-checking bench for the datapath self-test block
// Assumes: one bus word per register, index in adr[13:2]
// Notes:   counts are absolute, so scenarios run in a fixed order
`include "bist_consts.vh"
module datapath_loopback_bist_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [13:0] wb_adr_i = 14'h0000;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [7:0]  line_rxd_i = 8'h00;
  logic        line_rx_dv_i = 1'b0;
  logic        cable_loop = 1'b0;
  logic [7:0]  flip = 8'h00;
  logic        ltx_q = 1'b0;
  logic [7:0]  line_q[$];
  logic [15:0] rv;
  int          err_count = 0;
  int          cmp_count = 0;
  int          line_frames = 0;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o, link_clk_i, mac_tx_en_i, mac_rx_dv_o, line_tx_en_o, irq_o;
  wire  [7:0]  mac_txd_i, mac_rxd_o, line_txd_o;
  // block under test and its MAC partner
  datapath_loopback_bist #(.PKT_LEN_W(8)) u_datapath_loopback_bist (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .link_clk_i, .mac_txd_i, .mac_tx_en_i,
    .mac_rxd_o, .mac_rx_dv_o, .line_rxd_i, .line_rx_dv_i, .line_txd_o, .line_tx_en_o, .irq_o);
  mac_link_model u_mac_link_model (.link_clk_o(link_clk_i), .mac_txd_o(mac_txd_i), .mac_tx_en_o(mac_tx_en_i),
    .mac_rxd_i(mac_rxd_o), .mac_rx_dv_i(mac_rx_dv_o));
  // 50 ns system clock
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // cable stand-in turns the lane around when asked, with an optional byte fault
  always @(posedge clk_i) begin
    if (cable_loop) begin
      line_rx_dv_i <= line_tx_en_o;
      line_rxd_i   <= line_txd_o ^ flip;
    end
  end
  // record bytes leaving toward the cable, one per link slot
  always @(posedge link_clk_i) begin
    ltx_q <= line_tx_en_o;
    if (line_tx_en_o) line_q.push_back(line_txd_o);
    if (line_tx_en_o && !ltx_q) line_frames++;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one classic cycle; request held until ack is sampled, read data taken there
  task automatic bus(input logic we, input logic [11:0] idx, input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0000, wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) chk("bus ack", 16'h0001, 16'h0000);
    rv = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // cable frame of counting bytes from 8'h30, then one idle slot with the lane byte inverted
  task automatic line_send(input int n);
    for (int i = 0; i <= n; i++) begin
      @(negedge link_clk_i);
      @(posedge clk_i);
      line_rx_dv_i <= i < n;
      line_rxd_i   <= i < n ? 8'h30 + i[7:0] : ~line_rxd_i;
    end
  endtask
  task automatic t_regs;
    logic [11:0] rw[6] = '{`IDX_BASIC_CTRL, `IDX_LOOPBACK_CTRL, `IDX_CABLE_TX_CTRL, `IDX_SERIAL_CTRL,
                           `IDX_GEN_CTRL, `IDX_PKT_CONFIG};
    foreach (rw[i]) begin
      bus(0, rw[i], 16'h0000);
      chk("reset value", `RST_REG16, rv);
      bus(1, rw[i], 16'h5a5a);
      bus(0, rw[i], 16'h0000);
      chk("rw value", 16'h5a5a, rv);
      bus(1, rw[i], 16'h0000);
    end
    bus(1, `IDX_RX_CNT_LOW, 16'hffff);
    bus(0, `IDX_RX_CNT_LOW, 16'h0000);
    chk("count low read only", 16'h0000, rv);
    bus(1, 12'h123, 16'hffff);
    bus(0, 12'h123, 16'h0000);
    chk("unmapped", 16'h0000, rv);
  endtask
  task automatic t_mac_loop;
    bus(1, `IDX_BASIC_CTRL, 16'h4140);
    for (int k = 0; k < 2; k++) begin
      bus(1, `IDX_GEN_CTRL, k ? 16'h1114 : 16'h1004);
      u_mac_link_model.send_frame(20, 1'b0);
      u_mac_link_model.send_frame(33, 1'b1);
    end
    chk("echoed frames", 16'h0004, u_mac_link_model.echo_ok[15:0]);
    chk("cable copies", 16'h0004, line_frames[15:0]);
    bus(1, `IDX_CABLE_TX_CTRL, 16'h1000);
    u_mac_link_model.send_frame(64, 1'b0);
    chk("suppressed copy", 16'h0004, line_frames[15:0]);
    bus(0, `IDX_RX_CNT_LOW, 16'h0000);
    chk("packet count low", 16'h0005, rv);
    bus(0, `IDX_RX_CNT_HIGH, 16'h0000);
    chk("packet count high", 16'h0000, rv);
    bus(0, `IDX_CRC_ERR_CNT, 16'h0000);
    chk("crc error count", 16'h0002, rv);
    bus(1, `IDX_GEN_CTRL, 16'h0557);
    u_mac_link_model.send_frame(40, 1'b0);
    bus(0, `IDX_PRBS_STATUS, 16'h0000);
    chk("prbs in mac loop", 16'h0000, rv);
    bus(1, `IDX_IRQ_MASK, 16'h0001);
    repeat (2) @(posedge clk_i);
    chk("irq raised", 16'h0001, {15'h0000, irq_o});
    bus(0, `IDX_IRQ_STATUS, 16'h0000);
    chk("irq status", 16'h0003, rv);
    bus(1, `IDX_IRQ_STATUS, 16'h0001);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", 16'h0000, {15'h0000, irq_o});
    bus(1, `IDX_IRQ_MASK, 16'h0000);
    bus(1, `IDX_GEN_CTRL, 16'h0000);
    bus(1, `IDX_CABLE_TX_CTRL, 16'h0000);
    bus(1, `IDX_BASIC_CTRL, 16'h0000);
  endtask
  task automatic t_rev;
    for (int k = 0; k < 2; k++) begin
      bus(1, `IDX_LOOPBACK_CTRL, k ? 16'h0000 : 16'h0010);
      bus(1, `IDX_SERIAL_CTRL, k ? 16'h0010 : 16'h0000);
      line_q.delete();
      line_send(12);
      repeat (160) @(posedge clk_i);
      chk("turned count", 16'h000c, 16'(line_q.size()));
      foreach (line_q[i]) chk("turned byte", {8'h00, 8'h30 + i[7:0]}, {8'h00, line_q[i]});
    end
    bus(1, `IDX_SERIAL_CTRL, 16'h0000);
  endtask
  task automatic t_gen;
    bus(1, `IDX_PKT_CONFIG, 16'h55bf);
    bus(1, `IDX_GEN_CTRL, 16'h1555);
    cable_loop <= 1'b1;
    repeat (6000) @(posedge clk_i);
    bus(0, `IDX_RX_CNT_LOW, 16'h0000);
    chk("generated counted", 16'h0001, {15'h0000, rv > 16'h0006});
    bus(0, `IDX_CRC_ERR_CNT, 16'h0000);
    chk("clean crc count", 16'h0002, rv);
    bus(1, `IDX_GEN_CTRL, 16'h0557);
    repeat (400) @(posedge clk_i);
    bus(1, `IDX_PRBS_STATUS, 16'h0002);
    repeat (200) @(posedge clk_i);
    bus(0, `IDX_PRBS_STATUS, 16'h0000);
    chk("prbs clean lock", 16'h0100, rv);
    flip <= 8'h01;
    repeat (8) @(posedge clk_i);
    flip <= 8'h00;
    repeat (200) @(posedge clk_i);
    bus(0, `IDX_PRBS_STATUS, 16'h0000);
    chk("prbs errors seen", 16'h0001, {15'h0000, rv[7:0] != 8'h00});
    chk("prbs relocked", 16'h0001, {15'h0000, rv[8]});
    bus(1, `IDX_PRBS_STATUS, 16'h0002);
    bus(0, `IDX_PRBS_STATUS, 16'h0000);
    chk("prbs errors cleared", 16'h0100, rv);
    bus(1, `IDX_GEN_CTRL, 16'h0000);
    repeat (200) @(posedge clk_i);
    bus(0, `IDX_PRBS_STATUS, 16'h0000);
    chk("prbs lock dropped", 16'h0000, {15'h0000, rv[8]});
    cable_loop <= 1'b0;
    line_rx_dv_i <= 1'b0;
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // main sequence after a 20 cycle reset
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_mac_loop();
    t_rev();
    t_gen();
    summarize();
  end
  // watchdog: the run needs well under 1 ms
  initial begin
    #3000000;
    err_count++;
    summarize();
  end
endmodule // datapath_loopback_bist_tb
bind datapath_loopback_bist bist_checker #(.PKT_LEN_W(PKT_LEN_W)) u_bist_checker (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .link_clk_i, .mac_txd_i,
  .mac_tx_en_i, .mac_rxd_o, .mac_rx_dv_o, .line_rxd_i, .line_rx_dv_i, .line_txd_o, .line_tx_en_o, .irq_o);
